// file: rtl/wdtw_pkg.sv
// wdtw_pkg: register map, field positions, reset values and timing counts
// for the windowed watchdog timer.
// assumes: a single 10 MHz system clock; counter rate made by a divider.
`default_nettype none

package wdtw_pkg;
    // --------------------------------------------------------------
    // register offsets
    // --------------------------------------------------------------
    localparam int          ADDR_W        = 4;
    localparam int          DATA_W        = 8;
    localparam logic [3:0]  CTRL_OFF      = 4'h0;
    localparam logic [3:0]  TSEL_OFF      = 4'h1;
    localparam logic [3:0]  WARN_OFF      = 4'h2;
    localparam logic [3:0]  MASK_CLR_OFF  = 4'h4;
    localparam logic [3:0]  MASK_SET_OFF  = 4'h5;
    localparam logic [3:0]  PEND_OFF      = 4'h6;
    localparam logic [3:0]  SYNC_OFF      = 4'h7;
    localparam logic [3:0]  SERVICE_OFF   = 4'h8;

    // --------------------------------------------------------------
    // field positions and reset values
    // --------------------------------------------------------------
    localparam int          LOCK_BIT      = 7;
    localparam int          WIN_BIT       = 2;
    localparam int          EN_BIT        = 1;
    localparam int          OPEN_LSB      = 0;
    localparam int          CLOSED_LSB    = 4;
    localparam int          ALERT_BIT     = 0;
    localparam int          XDOM_BIT      = 1;
    localparam int          PEND_STAT_BIT = 7;
    localparam int          IRQ_W         = 2;
    localparam logic [7:0]  CTRL_RST      = 8'h00;
    localparam logic [7:0]  TSEL_RST      = 8'h00;
    localparam logic [3:0]  WARN_RST      = 4'h0;
    localparam logic [1:0]  MASK_RST      = 2'h0;
    localparam logic [7:0]  SERVICE_KEY   = 8'hA5;

    // --------------------------------------------------------------
    // span encoding and timing
    // --------------------------------------------------------------
    localparam int          CNT_W         = 16;
    localparam logic [15:0] SPAN_BASE     = 16'h0008;
    localparam logic [3:0]  SPAN_MAX_CODE = 4'hB;
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          CNT_PERIOD_NS = 1000000;
    localparam int          CNT_DIV       = CNT_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [1:0]  SYNC_TICKS    = 2'h2;

    typedef enum logic [0:0] {
        WDTW_SEL_CTRL = 1'b0,
        WDTW_SEL_SVC  = 1'b1
    } wdtw_sel_t;

    typedef enum logic [0:0] {
        WDTW_CLOSED = 1'b0,
        WDTW_OPEN   = 1'b1
    } wdtw_phase_t;
endpackage

`default_nettype wire

// file: rtl/wdtw_divider.sv
// wdtw_divider: makes the one-cycle counter-rate enable from the system clock.
// assumes: DIV of at least two.
`default_nettype none

module wdtw_divider #(
    parameter int DIV = wdtw_pkg::CNT_DIV
) (
    input  wire logic i_mclk,
    input  wire logic i_reset,
    output logic      o_tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } wdtw_div_t;

    wdtw_div_t q;
    wdtw_div_t d;

    // --------------------------------------------------------------
    // divider
    // --------------------------------------------------------------
    // free running: the counter rate must not pause when software is idle
    always_comb
    begin
        d      = q;
        d.tick = 1'b0;
        if (q.cnt == 16'(DIV - 1))
        begin
            d.cnt  = 16'h0000;
            d.tick = 1'b1;
        end
        else
        begin
            d.cnt = q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
            q <= '0;
        else
            q <= d;
    end

    assign o_tick = q.tick;
endmodule

`default_nettype wire

// file: rtl/wdtw_xdom.sv
// wdtw_xdom: carries a register write across to the counter rate.
// assumes: i_tick is a one-cycle enable; one write may wait behind another.
`default_nettype none

module wdtw_xdom (
    input  wire logic       i_mclk,
    input  wire logic       i_reset,
    input  wire logic       i_tick,
    input  wire logic       i_req,
    input  wire logic       i_sel,
    input  wire logic [7:0] i_data,
    output logic            o_busy,
    output logic            o_stall,
    output logic            o_apply,
    output logic            o_sel,
    output logic [7:0]      o_data
);
    typedef struct packed {
        logic       busy;
        logic [1:0] tcnt;
        logic       sel;
        logic [7:0] data;
        logic       hold;
        logic       hsel;
        logic [7:0] hdata;
        logic       apply;
        logic       osel;
        logic [7:0] odata;
    } wdtw_xdom_t;

    wdtw_xdom_t q;
    wdtw_xdom_t d;

    // --------------------------------------------------------------
    // transfer slot with one waiting entry
    // --------------------------------------------------------------
    // a write that arrives while busy waits in the hold slot, so it still
    // completes; a third write before that overwrites the waiting one
    always_comb
    begin
        d       = q;
        d.apply = 1'b0;
        if (q.busy && i_tick)
        begin
            if (q.tcnt == wdtw_pkg::SYNC_TICKS - 2'h1)
            begin
                d.apply = 1'b1;
                d.osel  = q.sel;
                d.odata = q.data;
                d.tcnt  = 2'h0;
                d.busy  = q.hold;
                d.sel   = q.hsel;
                d.data  = q.hdata;
                d.hold  = 1'b0;
            end
            else
            begin
                d.tcnt = q.tcnt + 2'h1;
            end
        end
        if (i_req)
        begin
            if (!d.busy)
            begin
                d.busy = 1'b1;
                d.tcnt = 2'h0;
                d.sel  = i_sel;
                d.data = i_data;
            end
            else
            begin
                d.hold  = 1'b1;
                d.hsel  = i_sel;
                d.hdata = i_data;
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
            q <= '0;
        else
            q <= d;
    end

    assign o_busy  = q.busy;
    assign o_stall = q.hold;
    assign o_apply = q.apply;
    assign o_sel   = q.osel;
    assign o_data  = q.odata;
endmodule

`default_nettype wire

// file: rtl/wdtw_core.sv
// wdtw_core: windowed watchdog with register port, early alert and lock.
// assumes: single 10 MHz clock; bus strobes are one cycle and never overlap.
`default_nettype none

// Behaviour
// R1: window mode uses closed span from closed_span_sel, open span from open_span_sel.
// R2: open window starts right after the closed window ends.
// R3: service during the closed window gives an immediate system reset.
// R4: expiry without service resets the system; early alert off after reset.
// R5: mask set register enables, mask clear register disables; both read shared state.
// R6: in window mode the early alert is raised when the open window begins.
// R7: with lock_run set the watchdog counts whatever the enable bit says.
// R8: lock_run stays set until power-on reset; writing zero does nothing.
// R9: with lock_run set, timing_sel_reg and warn_setup_reg ignore writes.
// R10: with lock_run set, window_select can still be written.
// R11: with lock_run set, mask set and clear registers still work.
// R12: window_select and alert enable pick four modes under lock_run.
// R13: pending flag and enable together hold the request until one drops.
// R14: all sources share one request line; software reads irq_pending_reg.
// R15: normal mode alert fires when count reaches the warn_lead_sel span.
// R16: a lead not shorter than the timeout never produces the alert.
// R17: synchronised write sets xdom_pending at once, clears it and flags xdom_done.
// R18: a write arriving while pending waits and still completes; the code holds one waiting write, and a further write overwrites it.
// R19: control_reg and service_key_reg writes cross to the counter rate.
// R20: writing 0xA5 to service_key_reg restarts; any other value resets.
// R21: span codes 0x0 to 0xB select 8 to 16384 counter cycles.
// R22: valid service in the open window restarts a fresh closed window.
// R23: writing one to a pending flag clears it; zero leaves it.
module wdtw_core #(
    parameter int CNT_DIV = wdtw_pkg::CNT_DIV
) (
    input  wire logic       i_mclk,
    input  wire logic       i_reset,
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic [7:0]      o_rdata,
    output logic            o_bus_stall,
    output logic            o_irq,
    output logic            o_sys_reset
);
    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    typedef struct packed {
        logic [7:0]            ctrl;
        logic [7:0]            tsel;
        logic [3:0]            warn;
        logic [1:0]            mask;
        logic [1:0]            pend;
        logic [7:0]            rdata;
        logic                  eff_en;
        logic                  eff_win;
        logic                  eff_lock;
        logic [15:0]           cnt;
        wdtw_pkg::wdtw_phase_t phase;
        logic                  sys_rst;
        logic                  irq;
    } wdtw_state_t;

    wdtw_state_t q;
    wdtw_state_t d;

    logic       tick;
    logic       sync_busy;
    logic       sync_stall;
    logic       apply;
    logic       apply_sel;
    logic [7:0] apply_data;
    logic       req;
    logic       req_sel;
    logic [7:0] req_data;

    // span in counter cycles; reserved codes clamp to the longest span
    function automatic logic [15:0] span(input logic [3:0] code);
        logic [3:0] c;
        c = (code > wdtw_pkg::SPAN_MAX_CODE) ? wdtw_pkg::SPAN_MAX_CODE : code;
        return wdtw_pkg::SPAN_BASE << c;
    endfunction

    // address match shared by read and write decode
    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        return a == off;
    endfunction

    // --------------------------------------------------------------
    // counter rate and write crossing
    // --------------------------------------------------------------
    wdtw_divider #(
        .DIV (CNT_DIV)
    ) u_div (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .o_tick  (tick)
    );

    wdtw_xdom u_xdom (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .i_tick  (tick),
        .i_req   (req),
        .i_sel   (req_sel),
        .i_data  (req_data),
        .o_busy  (sync_busy),
        .o_stall (sync_stall),
        .o_apply (apply),
        .o_sel   (apply_sel),
        .o_data  (apply_data)
    );

    // --------------------------------------------------------------
    // derived conditions
    // --------------------------------------------------------------
    logic        active;
    logic        in_closed;
    logic [15:0] nxt;
    logic        svc_apply;
    logic        ctl_wr;
    logic        svc_wr;

    assign active    = q.eff_en | q.eff_lock;                               // [R7]
    assign in_closed = q.eff_win && (q.phase == wdtw_pkg::WDTW_CLOSED);
    assign nxt       = q.cnt + 16'h0001;
    assign svc_apply = apply && (apply_sel == wdtw_pkg::WDTW_SEL_SVC);
    assign ctl_wr    = i_wr && hit(i_addr, wdtw_pkg::CTRL_OFF);
    assign svc_wr    = i_wr && hit(i_addr, wdtw_pkg::SERVICE_OFF);

    // both control and service writes travel through the crossing
    always_comb
    begin
        req      = ctl_wr || svc_wr;                                        // [R19]
        req_sel  = svc_wr;
        req_data = svc_wr ? i_wdata : d.ctrl;
    end

    // --------------------------------------------------------------
    // registers, counter and flags
    // --------------------------------------------------------------
    always_comb
    begin
        d         = q;
        d.sys_rst = 1'b0;
        d.rdata   = 8'h00;

        // bus writes; timing fields are frozen while running or locked
        if (ctl_wr)
        begin
            d.ctrl[wdtw_pkg::LOCK_BIT] = q.ctrl[wdtw_pkg::LOCK_BIT]
                                       | i_wdata[wdtw_pkg::LOCK_BIT];      // [R8]
            d.ctrl[wdtw_pkg::WIN_BIT]  = i_wdata[wdtw_pkg::WIN_BIT];        // [R10]
            if (!q.ctrl[wdtw_pkg::LOCK_BIT])
                d.ctrl[wdtw_pkg::EN_BIT] = i_wdata[wdtw_pkg::EN_BIT];
        end
        else if (i_wr && hit(i_addr, wdtw_pkg::TSEL_OFF))
        begin
            if (!q.ctrl[wdtw_pkg::LOCK_BIT] && !q.ctrl[wdtw_pkg::EN_BIT])
                d.tsel = i_wdata;                                           // [R9]
        end
        else if (i_wr && hit(i_addr, wdtw_pkg::WARN_OFF))
        begin
            if (!q.ctrl[wdtw_pkg::LOCK_BIT] && !q.ctrl[wdtw_pkg::EN_BIT])
                d.warn = i_wdata[3:0];                                      // [R9]
        end
        else if (i_wr && hit(i_addr, wdtw_pkg::MASK_SET_OFF))
        begin
            d.mask = q.mask | i_wdata[1:0];                                 // [R5] [R11]
        end
        else if (i_wr && hit(i_addr, wdtw_pkg::MASK_CLR_OFF))
        begin
            d.mask = q.mask & ~i_wdata[1:0];                                // [R5] [R11]
        end
        else if (i_wr && hit(i_addr, wdtw_pkg::PEND_OFF))
        begin
            d.pend = q.pend & ~i_wdata[1:0];                                // [R23]
        end

        // bus reads, data in the following cycle
        if (i_rd)
        begin
            if (hit(i_addr, wdtw_pkg::CTRL_OFF))
                d.rdata = q.ctrl & 8'h86;
            else if (hit(i_addr, wdtw_pkg::TSEL_OFF))
                d.rdata = q.tsel;
            else if (hit(i_addr, wdtw_pkg::WARN_OFF))
                d.rdata = {4'h0, q.warn};
            else if (hit(i_addr, wdtw_pkg::MASK_CLR_OFF) || hit(i_addr, wdtw_pkg::MASK_SET_OFF))
                d.rdata = {6'h00, q.mask};                                  // [R5]
            else if (hit(i_addr, wdtw_pkg::PEND_OFF))
                d.rdata = {6'h00, q.pend};                                  // [R14]
            else if (hit(i_addr, wdtw_pkg::SYNC_OFF))
                d.rdata = {sync_busy, 7'h00};                               // [R17]
            else
                d.rdata = 8'h00;
        end

        // control takes effect only after the crossing completes
        if (apply && (apply_sel == wdtw_pkg::WDTW_SEL_CTRL))
        begin
            d.eff_en   = apply_data[wdtw_pkg::EN_BIT];
            d.eff_win  = apply_data[wdtw_pkg::WIN_BIT];                     // [R12]
            d.eff_lock = q.eff_lock | apply_data[wdtw_pkg::LOCK_BIT];       // [R8]
        end
        if (apply)
            d.pend[wdtw_pkg::XDOM_BIT] = 1'b1;                              // [R17]

        // counting; a service arriving with a tick takes priority
        if (!active)
        begin
            d.cnt   = 16'h0000;
            d.phase = wdtw_pkg::WDTW_CLOSED;
        end
        else if (svc_apply)
        begin
            if (apply_data != wdtw_pkg::SERVICE_KEY)
                d.sys_rst = 1'b1;                                           // [R20]
            else if (in_closed)
                d.sys_rst = 1'b1;                                           // [R3]
            d.cnt   = 16'h0000;
            d.phase = wdtw_pkg::WDTW_CLOSED;                                // [R22]
        end
        else if (tick)
        begin
            if (in_closed)
            begin
                if (nxt == span(q.tsel[wdtw_pkg::CLOSED_LSB +: 4]))        // [R1] [R21]
                begin
                    d.cnt                       = 16'h0000;
                    d.phase                     = wdtw_pkg::WDTW_OPEN;      // [R2]
                    d.pend[wdtw_pkg::ALERT_BIT] = 1'b1;                     // [R6]
                end
                else
                    d.cnt = nxt;
            end
            else if (nxt == span(q.tsel[wdtw_pkg::OPEN_LSB +: 4]))         // [R21]
            begin
                d.sys_rst = 1'b1;                                           // [R4]
                d.cnt     = 16'h0000;
                d.phase   = wdtw_pkg::WDTW_CLOSED;
            end
            else
            begin
                d.cnt = nxt;
                // the timeout check above wins when the lead is too long
                if (!q.eff_win && nxt == span(q.warn))
                    d.pend[wdtw_pkg::ALERT_BIT] = 1'b1;                     // [R15] [R16]
            end
        end

        // one shared request line for every source
        d.irq = |(d.pend & d.mask);                                         // [R13] [R14]
    end

    always_ff @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            q       <= '0;
            q.ctrl  <= wdtw_pkg::CTRL_RST;
            q.tsel  <= wdtw_pkg::TSEL_RST;
            q.warn  <= wdtw_pkg::WARN_RST;
            q.mask  <= wdtw_pkg::MASK_RST;                                  // [R4]
        end
        else
            q <= d;
    end

    assign o_rdata     = q.rdata;
    assign o_irq       = q.irq;
    assign o_sys_reset = q.sys_rst;
    assign o_bus_stall = sync_stall;                                        // [R18]

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    lock_sticky_a: assert property (@(posedge i_mclk) disable iff (i_reset) // [R8]
        q.ctrl[wdtw_pkg::LOCK_BIT] |=> q.ctrl[wdtw_pkg::LOCK_BIT])
        else $error("lock bit dropped");

    cfg_frozen_a: assert property (@(posedge i_mclk) disable iff (i_reset) // [R9]
        (i_wr && i_addr == wdtw_pkg::TSEL_OFF && q.ctrl[wdtw_pkg::LOCK_BIT])
        |=> $stable(q.tsel))
        else $error("timing select changed while locked");

    win_locked_a: assert property (@(posedge i_mclk) disable iff (i_reset) // [R10]
        (ctl_wr && q.ctrl[wdtw_pkg::LOCK_BIT])
        |=> q.ctrl[wdtw_pkg::WIN_BIT] == $past(i_wdata[wdtw_pkg::WIN_BIT]))
        else $error("window select not written under lock");

    mask_set_a: assert property (@(posedge i_mclk) disable iff (i_reset) // [R5]
        (i_wr && i_addr == wdtw_pkg::MASK_SET_OFF && i_wdata[0])
        |=> q.mask[wdtw_pkg::ALERT_BIT])
        else $error("mask set did not enable alert");

    irq_level_a: assert property (@(posedge i_mclk) disable iff (i_reset) // [R13]
        o_irq == |(q.pend & q.mask))
        else $error("request not tied to flag and enable");

    xdom_pend_a: assert property (@(posedge i_mclk) disable iff (i_reset) // [R17]
        req |=> sync_busy ##1 (sync_busy || q.pend[wdtw_pkg::XDOM_BIT]))
        else $error("pending not raised on write");

    open_alert_a: assert property (@(posedge i_mclk) disable iff (i_reset) // [R6]
        (active && !svc_apply && tick && in_closed
         && nxt == span(q.tsel[wdtw_pkg::CLOSED_LSB +: 4]))
        |=> (q.phase == wdtw_pkg::WDTW_OPEN) && q.pend[wdtw_pkg::ALERT_BIT])
        else $error("open window start without alert");

    closed_svc_a: assert property (@(posedge i_mclk) disable iff (i_reset) // [R3]
        (active && svc_apply && in_closed) |=> o_sys_reset)
        else $error("service in closed window did not reset");

    bad_key_a: assert property (@(posedge i_mclk) disable iff (i_reset) // [R20]
        (active && svc_apply && apply_data != wdtw_pkg::SERVICE_KEY) |=> o_sys_reset)
        else $error("wrong key did not reset");

    timeout_a: assert property (@(posedge i_mclk) disable iff (i_reset) // [R4]
        (active && !svc_apply && tick && !in_closed
         && nxt == span(q.tsel[wdtw_pkg::OPEN_LSB +: 4]))
        |=> o_sys_reset ##1 !o_sys_reset)
        else $error("timeout did not reset for one cycle");

    warn_frozen_a: assert property (@(posedge i_mclk) disable iff (i_reset) // [R9]
        (i_wr && i_addr == wdtw_pkg::WARN_OFF && q.ctrl[wdtw_pkg::LOCK_BIT])
        |=> $stable(q.warn))
        else $error("warning lead changed while locked");

    mask_clr_a: assert property (@(posedge i_mclk) disable iff (i_reset) // [R5] [R11]
        (i_wr && i_addr == wdtw_pkg::MASK_CLR_OFF && i_wdata[0])
        |=> !q.mask[wdtw_pkg::ALERT_BIT])
        else $error("mask clear did not disable alert");

    // a completion in the same cycle wins over the clear, so that case is left out
    pend_clear_a: assert property (@(posedge i_mclk) disable iff (i_reset) // [R23]
        (i_wr && i_addr == wdtw_pkg::PEND_OFF && i_wdata[wdtw_pkg::XDOM_BIT] && !apply)
        |=> !q.pend[wdtw_pkg::XDOM_BIT])
        else $error("pending flag not cleared by one");

    lead_alert_a: assert property (@(posedge i_mclk) disable iff (i_reset) // [R15]
        (active && !svc_apply && tick && !q.eff_win && nxt == span(q.warn)
         && nxt != span(q.tsel[wdtw_pkg::OPEN_LSB +: 4]))
        |=> q.pend[wdtw_pkg::ALERT_BIT])
        else $error("normal mode alert missed at lead");
endmodule

`default_nettype wire

// file: verification/tb_top.sv
// tb_top: self-checking bench for the windowed watchdog core.
// assumes: wdtw_core alone on one clock, divider shortened to DIV.
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin errors++; \
    $display("BAD %s exp %h got %h", n, e, s); end end

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DIV = 4;
    logic        i_mclk, i_reset, i_wr, i_rd, o_bus_stall, o_irq, o_sys_reset;
    logic [3:0]  i_addr;
    logic [7:0]  i_wdata, o_rdata, rv, tv;
    logic [31:0] seed;
    logic        irq_prev;
    int          errors, tests_run, n, m, rst_cnt, irq_cnt;

    wdtw_core #(.CNT_DIV(DIV)) dut_u (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_bus_stall(o_bus_stall), .o_irq(o_irq), .o_sys_reset(o_sys_reset));

    // --------------------------------------------------------------
    // clock, event counters, helpers
    // --------------------------------------------------------------
    initial
    begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end

    // pulses are counted on the falling edge, where registered outputs have settled
    always @(negedge i_mclk)
    begin
        if (o_sys_reset === 1'b1) rst_cnt++;
        if (o_irq === 1'b1 && irq_prev !== 1'b1) irq_cnt++;
        irq_prev = o_irq;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // expected span in system cycles; codes above the top act as the top
    function automatic int span(input logic [3:0] c);
        return (8 << ((c > 4'hB) ? 11 : int'(c))) * DIV;
    endfunction

    task automatic close_out();
        if (errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // writes lower the strobe at their last edge, so the next call waits one edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_mclk);
        i_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_mclk);
        i_rd   <= 1'b0;
        @(negedge i_mclk);
        rv = o_rdata;
    endtask

    task automatic chk_rd(input string nm, input logic [3:0] a, input logic [7:0] e);
        rd(a);
        `CHK(nm, e, rv)
    endtask

    // bounded wait for irq (sel 0) or system reset (sel 1); n is cycles taken
    task automatic need(input int sel, input int lim, output int n);
        n = 0;
        do
        begin
            @(negedge i_mclk);
            n++;
        end while (((sel == 0) ? o_irq : o_sys_reset) !== 1'b1 && n < lim);
        if (((sel == 0) ? o_irq : o_sys_reset) !== 1'b1)
        begin
            errors++;
            close_out();
        end
    endtask

    task automatic sync_wait();
        int k;
        k = 0;
        do
        begin
            rd(4'h7);
            k++;
        end while (rv[7] !== 1'b0 && k < 20);
        if (rv[7] !== 1'b0)
        begin
            errors++;
            close_out();
        end
    endtask

    task automatic por();
        i_reset <= 1'b1;
        repeat (5) @(posedge i_mclk);
        i_reset <= 1'b0;
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial
    begin
        {i_reset, i_wr, i_rd, i_addr, i_wdata} = '0;
        {errors, tests_run, rst_cnt, irq_cnt} = '0;
        seed = 32'd8142;
        por();
        for (int a = 0; a < 9; a++) chk_rd("reset_val", a[3:0], 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            seed = xs(seed);
            wr(4'h1, seed[7:0]);
            chk_rd("tsel", 4'h1, seed[7:0]);
        end
        wr(4'h5, 8'h01);
        chk_rd("mask_clr", 4'h4, 8'h01);
        wr(4'h4, 8'h01);
        chk_rd("mask_set", 4'h5, 8'h00);
        // normal mode: open code 1, lead code 0, alert enabled
        wr(4'h1, 8'h01);
        wr(4'h2, 8'h00);
        wr(4'h5, 8'h01);
        wr(4'h0, 8'h02);
        chk_rd("pending", 4'h7, 8'h80);
        wr(4'h0, 8'h02);
        @(negedge i_mclk);
        `CHK("stall", 1'b1, o_bus_stall)
        sync_wait();
        rd(4'h6);
        `CHK("done_flag", 1'b1, rv[1])
        wr(4'h6, 8'h02);
        rd(4'h6);
        `CHK("w1c", 1'b0, rv[1])
        need(0, 400, n);
        need(1, 400, m);
        `CHK("lead_gap", 1'b1, (m >= span(1) - span(0) - 2 && m <= span(1) - span(0) + 2))
        rd(4'h6);
        `CHK("alert_flag", 1'b1, rv[0])
        wr(4'h6, 8'h01);
        @(negedge i_mclk);
        `CHK("irq_drop", 1'b0, o_irq)
        m = rst_cnt;
        for (int k = 0; k < 4; k++)
        begin
            wr(4'h8, 8'hA5);
            sync_wait();
        end
        `CHK("serviced", m, rst_cnt)
        seed = xs(seed);
        tv = (seed[7:0] == 8'hA5) ? 8'h5A : seed[7:0];
        wr(4'h8, tv);
        need(1, 14, n);
        // window mode: closed code 0, open code 1
        wr(4'h0, 8'h00);
        sync_wait();
        wr(4'h1, 8'h01);
        wr(4'h6, 8'h03);
        wr(4'h0, 8'h06);
        sync_wait();
        wr(4'h8, 8'hA5);
        need(1, 14, n);
        need(0, span(0) + 20, n);
        m = rst_cnt;
        wr(4'h8, 8'hA5);
        sync_wait();
        wr(4'h6, 8'h01);
        need(0, span(0) + 20, n);
        `CHK("open_service", m, rst_cnt)
        // lock: counting with enable off, protected fields
        wr(4'h0, 8'h80);
        sync_wait();
        wr(4'h0, 8'h00);
        sync_wait();
        chk_rd("lock_kept", 4'h0, 8'h80);
        wr(4'h0, 8'h84);
        sync_wait();
        chk_rd("win_sel", 4'h0, 8'h84);
        wr(4'h1, 8'hFF);
        chk_rd("tsel_ro", 4'h1, 8'h01);
        wr(4'h2, 8'h0F);
        chk_rd("warn_ro", 4'h2, 8'h00);
        wr(4'h4, 8'h03);
        chk_rd("lock_clr", 4'h5, 8'h00);
        wr(4'h5, 8'h01);
        chk_rd("lock_set", 4'h4, 8'h01);
        need(1, span(0) + span(1) + 40, n);
        // lead longer than the timeout: resets only
        por();
        wr(4'h1, 8'h00);
        wr(4'h2, 8'h01);
        wr(4'h5, 8'h01);
        wr(4'h0, 8'h02);
        m = irq_cnt;
        need(1, 200, n);
        need(1, span(0) + 10, n);
        `CHK("no_alert", m, irq_cnt)
        close_out();
    end
endmodule

`default_nettype wire
